/* lgci_defines.vh */
// Constants for the logic gate and contact input block.
`ifndef LGCI_DEFINES_VH
`define LGCI_DEFINES_VH
// Gate function codes.
`define FN_OR          3'h0
`define FN_NOR         3'h1
`define FN_AND         3'h2
`define FN_NAND        3'h3
`define FN_XOR         3'h4
`define FN_XNOR        3'h5
`define FN_B_LT_A      3'h6
`define FN_B_GT_A      3'h7
// Gate result targets; codes 1 to the relay count address relays.
`define TGT_NONE       4'h0
`define TGT_MAN_AUTO   4'h9
`define TGT_SP_SRC     4'hA
// Contact input actions.
`define ACT_NONE       4'h0
`define ACT_MAN        4'h1
`define ACT_SP1        4'h2
`define ACT_SP4        4'h5
`define ACT_DIR        4'h6
`define ACT_HOLD       4'h7
`define ACT_TOT        4'h8
// Setpoint source codes: remote, or local setpoint 1 to 4.
`define SP_REMOTE      3'h0
`define SP_LOCAL1      3'h1
// Timing.
`define CLK_FREQ_KHZ   50000
`define DEB_TIME_MS    10
`define DEB_CYCLES     (`DEB_TIME_MS * `CLK_FREQ_KHZ)
`define BLINK_TIME_MS  250
`define BLINK_CYCLES   (`BLINK_TIME_MS * `CLK_FREQ_KHZ)
// Comparator hysteresis, per mille of the operand B span.
`define HYST_PER_MILLE 1
`define B_SPAN         65535
`endif

/* logic_gates_contacts.v */
// Logic gate array and contact input actions for a two-loop process controller.
`include "lgci_defines.vh"
`default_nettype none

module logic_gates_contacts #(
	parameter NUM_GATES    = 5,
	parameter NUM_DI       = 4,
	parameter AW           = 16,
	parameter NUM_RELAYS   = 8,
	parameter DEB_CYCLES   = `DEB_CYCLES,
	parameter BLINK_CYCLES = `BLINK_CYCLES,
	parameter B_SPAN       = `B_SPAN
) (
	input  wire                    clk_sys,
	input  wire                    rst_b,
	input  wire [3*NUM_GATES-1:0]  gate_function_select,
	input  wire [4*NUM_GATES-1:0]  first_operand_source,
	input  wire [4*NUM_GATES-1:0]  second_operand_source,
	input  wire [4*NUM_GATES-1:0]  gate_result_target,
	input  wire [15:0]             dig_src,
	input  wire [4*AW-1:0]         ana_src,
	input  wire [NUM_RELAYS-1:0]   alarm_relay_claim,
	input  wire [NUM_RELAYS-1:0]   alarm_relay_drive,
	input  wire [NUM_RELAYS-1:0]   algo_relay_claim,
	input  wire [NUM_RELAYS-1:0]   algo_relay_drive,
	input  wire                    host_mode_ctrl,
	input  wire                    host_manual_cmd,
	input  wire                    host_sp_ctrl,
	input  wire                    host_remote_cmd,
	input  wire                    host_monitor,
	input  wire                    host_shed,
	input  wire [1:0]              key_man_auto,
	input  wire [1:0]              key_sp_sel,
	input  wire [1:0]              key_run_hold,
	input  wire [1:0]              prog_key_started,
	input  wire [1:0]              direct_cfg,
	input  wire [NUM_DI-1:0]       contact_raw,
	input  wire [4*NUM_DI-1:0]     contact_action_cfg,
	input  wire [NUM_DI-1:0]       contact_loop_cfg,
	output wire [NUM_GATES-1:0]    gate_result,
	output reg  [NUM_RELAYS-1:0]   relay_out_r,
	output reg  [1:0]              manual_r,
	output reg  [5:0]              sp_source_r,
	output reg  [1:0]              direct_action_r,
	output reg  [1:0]              program_hold_r,
	output reg                     key_error_r,
	output reg                     totalizer_reset_r,
	output reg  [NUM_DI-1:0]       contact_ind_r,
	output reg  [1:0]              manual_blink_r,
	output reg  [1:0]              sp_blink_r,
	output reg  [1:0]              hold_blink_r,
	output reg  [5:0]              local_setpoint_indication
);

	localparam CW = $clog2(DEB_CYCLES + 1);
	localparam BW = $clog2(BLINK_CYCLES + 1);
	localparam [CW-1:0] DEB_LAST   = DEB_CYCLES - 1;
	localparam [BW-1:0] BLINK_LAST = BLINK_CYCLES - 1;
	localparam [AW:0]   HYST       = (B_SPAN * `HYST_PER_MILLE) / 1000;

	// ---------------------------------------------------------------
	// Gate array
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_GATES; g = g + 1) begin : gate
			wire [2:0]    fn = gate_function_select[3*g +: 3];
			wire [3:0]    sa = first_operand_source[4*g +: 4], sb = second_operand_source[4*g +: 4];
			wire          da = dig_src[sa], db = dig_src[sb];
			wire [AW:0]   a  = {1'b0, ana_src[AW*sa[1:0] +: AW]};
			wire [AW:0]   b  = {1'b0, ana_src[AW*sb[1:0] +: AW]};
			reg           q_r, q_nxt;
			// The band only widens the release point, so a result that has
			// switched cannot drop back until B has moved clear of A.
			always @* begin
				case (fn)
					`FN_OR:     q_nxt = da | db;
					`FN_NOR:    q_nxt = ~(da | db);
					`FN_AND:    q_nxt = da & db;
					`FN_NAND:   q_nxt = ~(da & db);
					`FN_XOR:    q_nxt = da ^ db;
					`FN_XNOR:   q_nxt = ~(da ^ db);
					`FN_B_LT_A: q_nxt = q_r ? (b <= a + HYST) : (b < a);
					`FN_B_GT_A: q_nxt = q_r ? (b + HYST >= a) : (b > a);
					default:    q_nxt = 1'b0;
				endcase
			end
			always @(posedge clk_sys)
				q_r <= rst_b ? q_nxt : 1'b0;
			assign gate_result[g] = q_r;
		end
	endgenerate

	// ---------------------------------------------------------------
	// Gate result routing and arbitration
	// ---------------------------------------------------------------
	reg [NUM_RELAYS-1:0] gate_relay;
	reg                  gate_man_own, gate_man_val, gate_sp_own, gate_sp_val;
	integer              gi, ri;
	always @* begin
		gate_relay   = {NUM_RELAYS{1'b0}};
		gate_man_own = 1'b0;
		gate_man_val = 1'b0;
		gate_sp_own  = 1'b0;
		gate_sp_val  = 1'b0;
		for (gi = 0; gi < NUM_GATES; gi = gi + 1) begin
			for (ri = 0; ri < NUM_RELAYS; ri = ri + 1) begin
				if (gate_result_target[4*gi +: 4] == ri + 1)
					gate_relay[ri] = gate_relay[ri] | gate_result[gi];
			end
			if (gate_result_target[4*gi +: 4] == `TGT_MAN_AUTO) begin
				gate_man_own = 1'b1;
				gate_man_val = gate_man_val | gate_result[gi];
			end
			if (gate_result_target[4*gi +: 4] == `TGT_SP_SRC) begin
				gate_sp_own = 1'b1;
				gate_sp_val = gate_sp_val | gate_result[gi];
			end
		end
	end

	wire host_live     = ~host_monitor & ~host_shed;
	wire host_mode_eff = host_mode_ctrl & host_live;
	wire host_sp_eff   = host_sp_ctrl & host_live;
	wire gate_man_app  = gate_man_own & ~host_mode_eff;
	wire gate_sp_app   = gate_sp_own & ~host_sp_eff;
	wire [NUM_RELAYS-1:0] relay_nxt = (alarm_relay_claim & alarm_relay_drive)
		| (~alarm_relay_claim & algo_relay_claim & algo_relay_drive)
		| (~alarm_relay_claim & ~algo_relay_claim & gate_relay);
	// Gate ownership of mode and setpoint applies to loop 1.
	wire       man_lock  = gate_man_own & ~host_mode_eff;
	wire [1:0] man_key_ok = key_man_auto & {1'b1, ~man_lock};
	wire [1:0] sp_key_ok  = key_sp_sel & {1'b1, ~gate_sp_own};
	wire       key_rej    = (key_man_auto[0] & man_lock) | (key_sp_sel[0] & gate_sp_own);

	// ---------------------------------------------------------------
	// Contact synchronisers and debounce
	// ---------------------------------------------------------------
	reg  [NUM_DI-1:0] sync1_r, sync2_r, closed_q_r;
	wire [NUM_DI-1:0] closed_r;
	genvar d;
	generate
		for (d = 0; d < NUM_DI; d = d + 1) begin : deb
			reg [CW-1:0] cnt_r;
			reg          closed_bit_r;
			always @(posedge clk_sys) begin
				if (!rst_b || sync2_r[d] == closed_bit_r || cnt_r == DEB_LAST)
					cnt_r <= {CW{1'b0}};
				else
					cnt_r <= cnt_r + 1'b1;
				if (!rst_b)
					closed_bit_r <= 1'b0;
				else if (cnt_r == DEB_LAST && sync2_r[d] != closed_bit_r)
					closed_bit_r <= sync2_r[d];
			end
			assign closed_r[d] = closed_bit_r;
		end
	endgenerate

	// ---------------------------------------------------------------
	// Contact action decode per loop
	// ---------------------------------------------------------------
	reg [1:0]        mf, sf, df, hf;
	reg [5:0]        sp_num;
	reg              tot_edge;
	reg [NUM_DI-1:0] ind_nxt;
	reg [3:0]        act;
	integer          di;
	always @* begin
		mf       = 2'b00;
		sf       = 2'b00;
		sp_num   = 6'h00;
		df       = 2'b00;
		hf       = 2'b00;
		tot_edge = 1'b0;
		ind_nxt  = {NUM_DI{1'b0}};
		act      = `ACT_NONE;
		for (di = 0; di < NUM_DI; di = di + 1) begin
			act         = contact_action_cfg[4*di +: 4];
			ind_nxt[di] = closed_r[di] & (act != `ACT_NONE);
			if (closed_r[di] & ~closed_q_r[di] & (act == `ACT_TOT))
				tot_edge = 1'b1;
			if (closed_r[di]) begin
				if (act == `ACT_MAN)
					mf[contact_loop_cfg[di]] = 1'b1;
				if (act >= `ACT_SP1 && act <= `ACT_SP4) begin
					sf[contact_loop_cfg[di]] = 1'b1;
					sp_num[3*contact_loop_cfg[di] +: 3] = act[2:0] - 3'h1;
				end
				if (act == `ACT_DIR)
					df[contact_loop_cfg[di]] = 1'b1;
				if (act == `ACT_HOLD)
					hf[contact_loop_cfg[di]] = 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Loop mode state
	// ---------------------------------------------------------------
	reg [1:0] mf_q_r, sf_q_r, hf_q_r, prior_man_r, keep_man_r;
	reg [1:0] man_nxt, prior_man_nxt, keep_nxt, hold_nxt;
	reg [5:0] prior_sp_r, sp_nxt, prior_sp_nxt;
	integer   l;
	always @* begin
		man_nxt       = manual_r;
		prior_man_nxt = prior_man_r;
		keep_nxt      = keep_man_r;
		sp_nxt        = sp_source_r;
		prior_sp_nxt  = prior_sp_r;
		hold_nxt      = program_hold_r;
		for (l = 0; l < 2; l = l + 1) begin
			if (man_key_ok[l])
				man_nxt[l] = ~manual_r[l];
			if (l == 0 && gate_man_app)
				man_nxt[l] = gate_man_val;
			if (l == 0 && host_mode_eff)
				man_nxt[l] = host_manual_cmd;
			if (mf[l] & ~mf_q_r[l]) begin
				prior_man_nxt[l] = manual_r[l];
				keep_nxt[l]      = 1'b0;
			end else if (mf[l] & man_key_ok[l])
				keep_nxt[l] = 1'b1;
			if (mf[l])
				man_nxt[l] = 1'b1;
			else if (mf_q_r[l])
				man_nxt[l] = keep_man_r[l] | prior_man_r[l];
			if (sp_key_ok[l])
				sp_nxt[3*l +: 3] = (sp_source_r[3*l +: 3] == `SP_REMOTE) ?
					`SP_LOCAL1 : `SP_REMOTE;
			if (l == 0 && gate_sp_app)
				sp_nxt[2:0] = gate_sp_val ? `SP_REMOTE : `SP_LOCAL1;
			if (l == 0 && host_sp_eff)
				sp_nxt[2:0] = host_remote_cmd ? `SP_REMOTE : `SP_LOCAL1;
			if (sf[l] & ~sf_q_r[l])
				prior_sp_nxt[3*l +: 3] = sp_source_r[3*l +: 3];
			if (sf[l])
				sp_nxt[3*l +: 3] = sp_num[3*l +: 3];
			else if (sf_q_r[l])
				sp_nxt[3*l +: 3] = prior_sp_r[3*l +: 3];
			// A program not started from the run/hold key stays held after
			// reopening until that key releases it.
			if (key_run_hold[l])
				hold_nxt[l] = 1'b0;
			if (hf[l])
				hold_nxt[l] = 1'b1;
			else if (hf_q_r[l])
				hold_nxt[l] = ~prog_key_started[l];
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	reg [BW-1:0] blink_cnt_r;
	reg          blink_r;
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			sync1_r                   <= {NUM_DI{1'b0}};
			sync2_r                   <= {NUM_DI{1'b0}};
			closed_q_r                <= {NUM_DI{1'b0}};
			relay_out_r               <= {NUM_RELAYS{1'b0}};
			manual_r                  <= 2'b00;
			prior_man_r               <= 2'b00;
			keep_man_r                <= 2'b00;
			sp_source_r               <= {`SP_LOCAL1, `SP_LOCAL1};
			prior_sp_r                <= {`SP_LOCAL1, `SP_LOCAL1};
			direct_action_r           <= 2'b00;
			program_hold_r            <= 2'b00;
			mf_q_r                    <= 2'b00;
			sf_q_r                    <= 2'b00;
			hf_q_r                    <= 2'b00;
			key_error_r               <= 1'b0;
			totalizer_reset_r         <= 1'b0;
			contact_ind_r             <= {NUM_DI{1'b0}};
			manual_blink_r            <= 2'b00;
			sp_blink_r                <= 2'b00;
			hold_blink_r              <= 2'b00;
			local_setpoint_indication <= 6'h00;
			blink_cnt_r               <= {BW{1'b0}};
			blink_r                   <= 1'b0;
		end else begin
			sync1_r                   <= contact_raw;
			sync2_r                   <= sync1_r;
			closed_q_r                <= closed_r;
			relay_out_r               <= relay_nxt;
			manual_r                  <= man_nxt;
			prior_man_r               <= prior_man_nxt;
			keep_man_r                <= keep_nxt;
			sp_source_r               <= sp_nxt;
			prior_sp_r                <= prior_sp_nxt;
			direct_action_r           <= df | direct_cfg;
			program_hold_r            <= hold_nxt;
			mf_q_r                    <= mf;
			sf_q_r                    <= sf;
			hf_q_r                    <= hf;
			key_error_r               <= key_rej;
			totalizer_reset_r         <= tot_edge;
			contact_ind_r             <= ind_nxt;
			manual_blink_r            <= mf & {2{blink_r}};
			sp_blink_r                <= sf & {2{blink_r}};
			hold_blink_r              <= hf & {2{blink_r}};
			local_setpoint_indication <= sp_num;
			blink_r                   <= blink_r ^ (blink_cnt_r == BLINK_LAST);
			if (blink_cnt_r == BLINK_LAST)
				blink_cnt_r <= {BW{1'b0}};
			else
				blink_cnt_r <= blink_cnt_r + 1'b1;
		end
	end

endmodule

`default_nettype wire

/* contact_switches.sv */
// Behavioural model of four external contacts that bounce on every change.
`default_nettype none
module contact_switches (
	input  wire logic       clk_sys,
	input  wire logic [3:0] want,
	output logic      [3:0] contact_raw
);
timeunit 1ns;
timeprecision 1ps;
// -----------------------------------------------------------------
// Bounce
// -----------------------------------------------------------------
// Each change chatters for five cycles, so only a real debouncer sees it once.
logic [3:0] last_r = 4'h0;
logic [3:0] chg_r = 4'h0;
logic [2:0] cnt_r = 3'h0;
always @(posedge clk_sys) begin
	if (want != last_r) begin
		chg_r <= want ^ last_r;
		last_r <= want;
		cnt_r <= 3'h5;
	end else if (cnt_r != 3'h0) begin
		cnt_r <= cnt_r - 3'h1;
	end
end
assign contact_raw = cnt_r[0] ? last_r ^ chg_r : last_r;
endmodule
`default_nettype wire

/* lgc_props.sv */
// Concurrent checks on the ports of the logic gate and contact input block.
`include "lgci_defines.vh"
`default_nettype none
module lgc_props #(
	parameter int NUM_GATES  = 5,
	parameter int NUM_DI     = 4,
	parameter int NUM_RELAYS = 8,
	parameter int DEB_CYCLES = 4
) (
	input wire logic                  clk_sys,
	input wire logic                  rst_b,
	input wire logic [3*NUM_GATES-1:0] gate_function_select,
	input wire logic [4*NUM_GATES-1:0] first_operand_source,
	input wire logic [4*NUM_GATES-1:0] second_operand_source,
	input wire logic [15:0]           dig_src,
	input wire logic [NUM_RELAYS-1:0] alarm_relay_claim,
	input wire logic [NUM_RELAYS-1:0] alarm_relay_drive,
	input wire logic [NUM_RELAYS-1:0] algo_relay_claim,
	input wire logic [NUM_RELAYS-1:0] algo_relay_drive,
	input wire logic [1:0]            key_man_auto,
	input wire logic [1:0]            key_sp_sel,
	input wire logic [NUM_DI-1:0]     contact_raw,
	input wire logic [4*NUM_DI-1:0]   contact_action_cfg,
	input wire logic [NUM_GATES-1:0]  gate_result,
	input wire logic [NUM_RELAYS-1:0] relay_out_r,
	input wire logic [1:0]            manual_r,
	input wire logic                  key_error_r,
	input wire logic                  totalizer_reset_r,
	input wire logic [NUM_DI-1:0]     contact_ind_r,
	input wire logic [1:0]            manual_blink_r
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_b);
function automatic logic bool_fn(input logic [2:0] f, input logic a, input logic b);
	case (f)
		3'h0: return a | b;
		3'h1: return ~(a | b);
		3'h2: return a & b;
		3'h3: return ~(a & b);
		3'h4: return a ^ b;
		default: return ~(a ^ b);
	endcase
endfunction
logic exp_r;
int   stab_r;
wire  key_any = key_man_auto[0] | key_sp_sel[0];
always @(posedge clk_sys) begin
	exp_r <= bool_fn(gate_function_select[2:0], dig_src[first_operand_source[3:0]],
		dig_src[second_operand_source[3:0]]);
	stab_r <= !contact_raw[0] ? 0 : (stab_r < 99 ? stab_r + 1 : stab_r);
end
a_gate_bool: assert property (gate_function_select[2:0] < 3'h6 |=> gate_result[0] == exp_r)
	else $error("gate 0 boolean result wrong");
a_alarm_owns: assert property ((alarm_relay_claim[0] && $stable(alarm_relay_drive[0]))[*3]
	|-> relay_out_r[0] == alarm_relay_drive[0]) else $error("alarm lost relay 1");
a_algo_owns: assert property ((!alarm_relay_claim[0] && algo_relay_claim[0]
	&& $stable(algo_relay_drive[0]))[*3] |-> relay_out_r[0] == algo_relay_drive[0])
	else $error("output algorithm lost relay 1");
a_key_err_pulse: assert property (key_error_r |=> !key_error_r)
	else $error("key error longer than one cycle");
a_key_err_cause: assert property (key_error_r |-> $past(key_any) || $past(key_any, 2))
	else $error("key error without a key press");
a_tot_pulse: assert property (totalizer_reset_r |=> !totalizer_reset_r)
	else $error("totalizer reset longer than one cycle");
a_ind_none: assert property ((contact_action_cfg[3:0] == 4'h0)[*2] |-> !contact_ind_r[0])
	else $error("indicator lit with no action");
a_man_blink: assert property (manual_blink_r[0] |-> manual_r[0])
	else $error("manual blink outside manual");
a_debounce_hold: assert property ($rose(contact_ind_r[0]) |-> stab_r >= DEB_CYCLES)
	else $error("contact accepted before debounce");
endmodule
bind logic_gates_contacts lgc_props #(.NUM_GATES(NUM_GATES), .NUM_DI(NUM_DI),
	.NUM_RELAYS(NUM_RELAYS), .DEB_CYCLES(DEB_CYCLES)) u_props (.clk_sys, .rst_b,
	.gate_function_select, .first_operand_source, .second_operand_source, .dig_src,
	.alarm_relay_claim, .alarm_relay_drive, .algo_relay_claim, .algo_relay_drive,
	.key_man_auto, .key_sp_sel, .contact_raw, .contact_action_cfg, .gate_result,
	.relay_out_r, .manual_r, .key_error_r, .totalizer_reset_r, .contact_ind_r,
	.manual_blink_r);
`default_nettype wire

/* logic_gates_contacts_test.sv */
// Self-checking bench for the logic gate and contact input block.
`default_nettype none
module logic_gates_contacts_test;
timeunit 1ns;
timeprecision 1ps;
// -----------------------------------------------------------------
// Signals and instances
// -----------------------------------------------------------------
logic        clk_sys = 0;
logic        rst_b = 0;
logic [14:0] gate_function_select = 0;
logic [19:0] first_operand_source = 0, second_operand_source = 0, gate_result_target = 0;
logic [15:0] dig_src = 0, contact_action_cfg = 0;
logic [63:0] ana_src = 0;
logic [7:0]  alarm_relay_claim = 0, alarm_relay_drive = 0;
logic [7:0]  algo_relay_claim = 0, algo_relay_drive = 0;
logic        host_mode_ctrl = 0, host_manual_cmd = 0, host_sp_ctrl = 0;
logic        host_remote_cmd = 0, host_monitor = 0, host_shed = 0;
logic [1:0]  key_man_auto = 0, key_sp_sel = 0, key_run_hold = 0;
logic [1:0]  prog_key_started = 0, direct_cfg = 0;
logic [3:0]  want = 0, contact_loop_cfg = 0;
wire  [3:0]  contact_raw, contact_ind_r;
wire  [4:0]  gate_result;
wire  [7:0]  relay_out_r;
wire  [1:0]  manual_r, direct_action_r, program_hold_r, manual_blink_r, sp_blink_r, hold_blink_r;
wire  [5:0]  sp_source_r, local_setpoint_indication;
wire         key_error_r, totalizer_reset_r;
int          n_errors = 0, checked = 0, cyc = 0, ntot;
logic [2:0]  seen;
logic        e;
contact_switches i_sw (.clk_sys, .want, .contact_raw);
// Short debounce and blink counts keep the run brief.
logic_gates_contacts #(.DEB_CYCLES(4), .BLINK_CYCLES(8)) i_dut (.clk_sys, .rst_b,
	.gate_function_select, .first_operand_source, .second_operand_source,
	.gate_result_target, .dig_src, .ana_src, .alarm_relay_claim, .alarm_relay_drive,
	.algo_relay_claim, .algo_relay_drive, .host_mode_ctrl, .host_manual_cmd, .host_sp_ctrl,
	.host_remote_cmd, .host_monitor, .host_shed, .key_man_auto, .key_sp_sel, .key_run_hold,
	.prog_key_started, .direct_cfg, .contact_raw, .contact_action_cfg, .contact_loop_cfg,
	.gate_result, .relay_out_r, .manual_r, .sp_source_r, .direct_action_r, .program_hold_r,
	.key_error_r, .totalizer_reset_r, .contact_ind_r, .manual_blink_r, .sp_blink_r,
	.hold_blink_r, .local_setpoint_indication);
initial forever #10 clk_sys = ~clk_sys;
always @(posedge clk_sys) begin
	cyc++;
	if (cyc == 5000) begin
		n_errors++;
		print_verdict;
	end
end
// -----------------------------------------------------------------
// Shared tasks
// -----------------------------------------------------------------
task automatic cy(input int n);
	repeat (n) @(negedge clk_sys);
endtask
task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
	checked++;
	if (got !== exp) begin
		n_errors++;
		$display("BAD %s expected %h seen %h", what, exp, got);
	end
endtask
task automatic do_reset;
	rst_b = 0;
	cy(4);
	rst_b = 1;
endtask
task automatic press(ref logic [1:0] k, output logic err);
	k[0] = 1;
	cy(1);
	// The key error pulse stands for the cycle right after the press.
	err = key_error_r;
	k[0] = 0;
	repeat (2) begin
		cy(1);
		err |= key_error_r;
	end
endtask
task automatic dio(input int i, input logic v);
	want[i] = v;
	ntot = 0;
	seen = 0;
	repeat (24) begin
		cy(1);
		ntot += int'(totalizer_reset_r);
		seen |= {hold_blink_r[0], sp_blink_r[0], manual_blink_r[0]};
	end
	chk("indicator", 8'(v && contact_action_cfg[4*i+:4] != 0), 8'(contact_ind_r[i]));
endtask
// -----------------------------------------------------------------
// Scenarios
// -----------------------------------------------------------------
task automatic t_bool;
	do_reset;
	second_operand_source = 20'h11111;
	for (int f = 0; f < 6; f++) begin
		for (int v = 0; v < 4; v++) begin
			gate_function_select = {5{3'(f)}};
			dig_src[1:0] = 2'(v);
			cy(2);
			case (f)
				0: e = v != 0;
				1: e = v == 0;
				2: e = v == 3;
				3: e = v != 3;
				4: e = v == 1 || v == 2;
				default: e = v == 0 || v == 3;
			endcase
			chk("gates", {3'h0, {5{e}}}, {3'h0, gate_result});
		end
	end
endtask
task automatic t_cmp;
	logic [15:0] bv[8] = '{16'h03E7, 16'h041A, 16'h0429, 16'h042A,
		16'h03E8, 16'h03A8, 16'h03A7, 16'h03A6};
	logic [1:0] ev[8] = '{2'h1, 2'h3, 2'h3, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1};
	do_reset;
	gate_function_select = 15'h003E;
	first_operand_source = 20'h0;
	second_operand_source = 20'h00011;
	ana_src[15:0] = 16'h03E8;
	for (int i = 0; i < 8; i++) begin
		ana_src[31:16] = bv[i];
		cy(2);
		chk("compare", {6'h0, ev[i]}, {6'h0, gate_result[1:0]});
	end
endtask
task automatic t_relay;
	do_reset;
	gate_function_select = 0;
	first_operand_source = 20'h00022;
	second_operand_source = 20'h00022;
	dig_src = 16'h0004;
	gate_result_target = 20'h00001;
	cy(3);
	chk("relay", 8'h01, relay_out_r);
	alarm_relay_claim = 8'h01;
	cy(3);
	chk("relay", 8'h00, relay_out_r);
	alarm_relay_claim = 8'h00;
	algo_relay_claim = 8'h01;
	cy(3);
	chk("relay", 8'h00, relay_out_r);
	algo_relay_claim = 8'h00;
	gate_result_target = 20'h000A9;
	cy(3);
	chk("manual", 8'h01, manual_r);
	chk("sp source", 8'h00, sp_source_r[2:0]);
	host_mode_ctrl = 1;
	host_sp_ctrl = 1;
	cy(3);
	chk("manual", 8'h00, manual_r);
	chk("sp source", 8'h01, sp_source_r[2:0]);
	press(key_man_auto, e);
	chk("key error", 8'h00, e);
	host_monitor = 1;
	cy(3);
	chk("manual", 8'h01, manual_r);
	host_monitor = 0;
	host_shed = 1;
	cy(3);
	chk("sp source", 8'h00, sp_source_r[2:0]);
	host_shed = 0;
	host_mode_ctrl = 0;
	host_sp_ctrl = 0;
	press(key_man_auto, e);
	chk("key error", 8'h01, e);
	press(key_sp_sel, e);
	chk("key error", 8'h01, e);
endtask
task automatic t_contact;
	do_reset;
	gate_result_target = 0;
	contact_action_cfg = 16'h0001;
	dio(0, 1);
	chk("manual", 8'h01, manual_r);
	chk("man blink", 8'h01, seen[0]);
	dio(0, 0);
	chk("manual", 8'h00, manual_r);
	dio(0, 1);
	press(key_man_auto, e);
	dio(0, 0);
	chk("manual", 8'h01, manual_r);
	do_reset;
	want[0] = 1;
	cy(2);
	want[0] = 0;
	cy(20);
	chk("glitch", 8'h00, manual_r);
	contact_loop_cfg = 4'h2;
	contact_action_cfg = 16'h0010;
	dio(1, 1);
	chk("manual", 8'h02, manual_r);
	dio(1, 0);
	do_reset;
	contact_loop_cfg = 4'h0;
	press(key_sp_sel, e);
	for (int n = 1; n < 5; n++) begin
		contact_action_cfg = 16'(n + 1);
		dio(0, 1);
		chk("sp source", 8'(n), sp_source_r[2:0]);
		chk("sp number", 8'(n), local_setpoint_indication[2:0]);
		chk("sp blink", 8'h01, seen[1]);
		dio(0, 0);
		chk("sp source", 8'h00, sp_source_r[2:0]);
	end
	contact_action_cfg = 16'h0006;
	dio(0, 1);
	chk("direct", 8'h01, direct_action_r);
	dio(0, 0);
	chk("direct", 8'h00, direct_action_r);
	contact_action_cfg = 16'h0007;
	prog_key_started = 2'h1;
	dio(0, 1);
	chk("hold", 8'h01, program_hold_r);
	chk("hold blink", 8'h01, seen[2]);
	dio(0, 0);
	chk("hold", 8'h00, program_hold_r);
	prog_key_started = 2'h0;
	dio(0, 1);
	dio(0, 0);
	chk("hold", 8'h01, program_hold_r);
	press(key_run_hold, e);
	chk("hold", 8'h00, program_hold_r);
	contact_action_cfg = 16'h0008;
	dio(0, 1);
	chk("tot pulses", 8'h01, 8'(ntot));
	dio(0, 0);
	chk("tot pulses", 8'h00, 8'(ntot));
	contact_action_cfg = 16'h0000;
	dio(0, 1);
	dio(0, 0);
endtask
task automatic print_verdict;
	$display("errors %0d checks %0d", n_errors, checked);
	if (n_errors == 0 && checked > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
initial begin
	do_reset;
	t_bool;
	t_cmp;
	t_relay;
	t_contact;
	print_verdict;
end
endmodule
`default_nettype wire
